// [lut_dac_control_registers_tb_top.sv]
// Self-checking testbench for the current generator register bank
`timescale 1ns/1ps
module lut_dac_control_registers_tb_top;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_q;
  logic       reg_ack_q;
  logic       reg_nack_q;
  logic       nv_wr_q;
  logic [7:0] nv_addr_q;
  logic [7:0] nv_data_q;
  logic       adc_done = 1'b0;
  logic [7:0] adc_result = 8'h00;
  logic [7:0] lut_rdata;
  logic [7:0] lut_row_addr_q;
  logic [7:0] dac_code_q;
  logic       current_sink_q;
  logic [1:0] full_scale_range_q;
  int         miscompares = 0;
  int         cmp_count = 0;

  always #2.5 clk_sys = ~clk_sys;

  // Recall path left idle: cells start from the bank's own reset values
  lutd_regs i_lutd_regs (.clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
    .reg_nack_q(reg_nack_q), .nv_load(1'b0), .nv_load_addr(8'h00), .nv_load_data(8'h00),
    .nv_wr_q(nv_wr_q), .nv_addr_q(nv_addr_q), .nv_data_q(nv_data_q), .adc_done(adc_done),
    .adc_result(adc_result), .lut_rdata(lut_rdata), .lut_row_addr_q(lut_row_addr_q),
    .dac_code_q(dac_code_q), .current_sink_q(current_sink_q), .full_scale_range_q(full_scale_range_q));

  lutd_lut_model i_lutd_lut_model (.clk_sys(clk_sys), .lut_row_addr(lut_row_addr_q), .lut_rdata(lut_rdata),
    .nv_wr(nv_wr_q), .nv_addr(nv_addr_q), .nv_data(nv_data_q));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write, answer sampled once the next edge has landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ack, input logic nv);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
    chk({5'h00, nv_wr_q, reg_nack_q, reg_ack_q}, {5'h00, nv, ~ack, ack});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask

  task automatic conv(input logic [7:0] v);
    @(posedge clk_sys);
    adc_done   <= 1'b1;
    adc_result <= v;
    @(posedge clk_sys);
    adc_done <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #20000;
    miscompares++;
    wrap_up();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    settle();
    chk({7'h00, current_sink_q}, 8'h00);
    chk({6'h00, full_scale_range_q}, 8'h03);
    chk(lut_row_addr_q, 8'h90);
    chk(dac_code_q, 8'h00);
    rd(8'h80, 8'h80);
    rd(8'h85, 8'h03);
    rd(8'h86, 8'h00);
    rd(8'h87, 8'h00);
    $display("test reset_values done");
    wr(8'h81, 8'h05, 1'b0, 1'b0);
    rd(8'h81, 8'h00);
    wr(8'h86, 8'h80, 1'b1, 1'b0);
    rd(8'h86, 8'h80);
    wr(8'h86, 8'h55, 1'b1, 1'b0);
    rd(8'h86, 8'h80);
    $display("test write_latch done");
    wr(8'h80, 8'hC0, 1'b1, 1'b1);
    settle();
    chk({7'h00, current_sink_q}, 8'h01);
    rd(8'h80, 8'hC0);
    wr(8'h81, 8'h3F, 1'b1, 1'b0);
    rd(8'h81, 8'h3F);
    wr(8'h80, 8'hA0, 1'b1, 1'b1);
    settle();
    chk({7'h00, current_sink_q}, 8'h00);
    wr(8'h83, 8'hC7, 1'b1, 1'b1);
    chk(nv_addr_q, 8'h83);
    chk(nv_data_q, 8'hC7);
    rd(8'h83, 8'hC7);
    chk(i_lutd_lut_model.nv_cell[8'h83], 8'hC7);
    $display("test volatility done");
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h88 + 8'(i), 8'hFF, 1'b1, 1'b0);
      rd(8'h88 + 8'(i), 8'h00);
    end
    wr(8'h82, 8'hFF, 1'b1, 1'b0);
    rd(8'h82, 8'h00);
    wr(8'h84, 8'hFF, 1'b1, 1'b0);
    rd(8'h84, 8'h00);
    wr(8'h87, 8'hFF, 1'b1, 1'b0);
    rd(8'h87, 8'h00);
    $display("test reserved done");
    wr(8'h85, 8'h13, 1'b1, 1'b1);
    settle();
    chk(lut_row_addr_q, 8'hCF);
    chk(dac_code_q, 8'hF3);
    wr(8'h85, 8'h33, 1'b1, 1'b1);
    settle();
    chk(dac_code_q, 8'hC7);
    for (int r = 1; r < 4; r++)
    begin
      wr(8'h85, 8'h30 | 8'(r), 1'b1, 1'b1);
      settle();
      chk({6'h00, full_scale_range_q}, 8'(r));
    end
    $display("test source_select done");
    wr(8'h80, 8'h90, 1'b1, 1'b1);
    wr(8'h85, 8'h03, 1'b1, 1'b1);
    conv(8'h5A);
    rd(8'h87, 8'h5A);
    settle();
    chk(lut_row_addr_q, 8'hA6);
    chk(dac_code_q, 8'h9A);
    wr(8'h80, 8'h80, 1'b1, 1'b1);
    repeat (3) conv(8'hA0);
    rd(8'h87, 8'h5A);
    conv(8'hA0);
    rd(8'h87, 8'hA0);
    settle();
    chk(lut_row_addr_q, 8'hB8);
    $display("test adc_filter done");
    wr(8'h86, 8'h00, 1'b1, 1'b0);
    wr(8'h85, 8'h13, 1'b0, 1'b0);
    rd(8'h85, 8'h03);
    $display("test latch_clear done");
    wrap_up();
  end
endmodule

// [lutd_lut_model.sv]
// Far-side model: LUT array and nonvolatile cells seen by the register bank
`timescale 1ns/1ps
module lutd_lut_model
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] lut_row_addr,
  output logic      [7:0] lut_rdata,
  input  wire logic       nv_wr,
  input  wire logic [7:0] nv_addr,
  input  wire logic [7:0] nv_data
);
  logic [7:0] nv_cell [128:255];

  // Pattern differs per row so a wrong row shows up at the DAC
  assign lut_rdata = lut_row_addr ^ 8'h3C;

  // Captures settings that must survive power-down
  always_ff @(posedge clk_sys)
  begin
    if (nv_wr)
      nv_cell[nv_addr] <= nv_data;
  end
endmodule

// [lutd_pkg.sv]
// Constants for the current generator control and status register bank
// Overview of operation
// - Bypass on: status follows every conversion
// - Bypass off: update after four agreeing conversions
// - Volatility 0: override writes stay volatile only
// - Volatility 1: override writes also go nonvolatile
// - Direction bit: 0 sources, 1 sinks current
// - Addresses 82h, 84h, 88h-8Fh are reserved
// - Row override at 81h, volatility selectable
// - LUT direct select: row from override bits
// - LUT direct clear: row from status at 87h (filtered ADC result)
// - Row address is 90h plus row value
// - DAC direct select: DAC fed from override
// - DAC direct clear: DAC fed from LUT once status valid or LUT direct set, else zero
// - DAC override at 83h, volatility selectable
// - Source and range register at 85h
// - Range field: 00 reserved, 11 default
// - Write latch gates writes; set 80h, clear 00h
// - Status at 87h read only, drives row
package lutd_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ROW_W  = 6;

  localparam logic [7:0] ADDR_CURRENT_CONFIG = 8'h80;
  localparam logic [7:0] ADDR_LUT_ROW_OVR    = 8'h81;
  localparam logic [7:0] ADDR_DAC_CODE_OVR   = 8'h83;
  localparam logic [7:0] ADDR_SOURCE_RANGE   = 8'h85;
  localparam logic [7:0] ADDR_WRITE_LATCH    = 8'h86;
  localparam logic [7:0] ADDR_TEMP_CODE      = 8'h87;
  localparam logic [7:0] LUT_BASE_ADDR       = 8'h90;

  // current_config fields
  localparam int unsigned CFG_FIXED_ONE_BIT  = 7;
  localparam int unsigned CFG_DIRECTION_BIT  = 6;
  localparam int unsigned CFG_VOLATILITY_BIT = 5;
  localparam int unsigned CFG_BYPASS_BIT     = 4;
  // source_and_range_select fields
  localparam int unsigned SRC_DAC_DIRECT_BIT = 5;
  localparam int unsigned SRC_LUT_DIRECT_BIT = 4;
  localparam int unsigned SRC_RANGE_HI_BIT   = 1;
  localparam int unsigned SRC_RANGE_LO_BIT   = 0;
  // write_latch_control
  localparam int unsigned WEL_BIT            = 7;
  localparam logic [7:0]  WEL_SET_CODE       = 8'h80;
  localparam logic [7:0]  WEL_CLEAR_CODE     = 8'h00;

  localparam logic [1:0] RANGE_RESERVED = 2'h0;
  localparam logic [1:0] RANGE_LOW      = 2'h1;
  localparam logic [1:0] RANGE_MIDDLE   = 2'h2;
  localparam logic [1:0] RANGE_HIGH     = 2'h3;

  // Reset values until recall from nonvolatile cells
  localparam logic       RST_DIRECTION  = 1'b0;
  localparam logic       RST_VOLATILITY = 1'b0;
  localparam logic       RST_BYPASS     = 1'b0;
  localparam logic       RST_DAC_DIRECT = 1'b0;
  localparam logic       RST_LUT_DIRECT = 1'b0;
  localparam logic [1:0] RST_RANGE      = RANGE_HIGH;
  localparam logic [7:0] RST_BYTE       = 8'h00;

  // Agreeing conversions before a filtered update; the count holds
  // earlier matches, so the last agreeing result finds two of them
  localparam int unsigned FILTER_AGREE  = 4;
  localparam logic [1:0]  AGREE_FULL    = 2'(FILTER_AGREE - 2);
  localparam logic [1:0]  AGREE_ZERO    = 2'h0;
endpackage

// [lutd_regs.sv]
// Control and status register bank with DAC source selection
`timescale 1ns/1ps
module lutd_regs
(
  input  wire logic                         clk_sys,
  input  wire logic                         reset_n,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [lutd_pkg::DATA_W-1:0]  reg_wdata,
  output logic      [lutd_pkg::DATA_W-1:0]  reg_rdata_q,
  output logic                              reg_ack_q,
  output logic                              reg_nack_q,
  input  wire logic                         nv_load,
  input  wire logic [7:0]                   nv_load_addr,
  input  wire logic [lutd_pkg::DATA_W-1:0]  nv_load_data,
  output logic                              nv_wr_q,
  output logic      [7:0]                   nv_addr_q,
  output logic      [lutd_pkg::DATA_W-1:0]  nv_data_q,
  input  wire logic                         adc_done,
  input  wire logic [lutd_pkg::DATA_W-1:0]  adc_result,
  input  wire logic [lutd_pkg::DATA_W-1:0]  lut_rdata,
  output logic      [7:0]                   lut_row_addr_q,
  output logic      [lutd_pkg::DATA_W-1:0]  dac_code_q,
  output logic                              current_sink_q,
  output logic      [1:0]                   full_scale_range_q
);
  import lutd_pkg::*;

  logic                  adc_filter_bypass_q;
  logic                  override_volatility_select_q;
  logic [ROW_W-1:0]      lut_row_override_bits_q;
  logic [DATA_W-1:0]     dac_code_override_bits_q;
  logic                  dac_direct_select_q;
  logic                  lut_direct_select_q;
  logic                  write_enable_latch_q;
  logic [DATA_W-1:0]     thermometer_code_bits_q;
  logic                  status_valid_q;
  logic [ROW_W-1:0]      last_upper_q;
  logic [1:0]            agree_cnt_q;
  logic                  first_seen_q;
  logic                  wr_ok;
  logic                  wel_write;
  logic                  upper_match;
  logic [ROW_W-1:0]      row_sel;
  logic [DATA_W-1:0]     rd_d;
  logic                  override_write;

  // Latch writes are always taken so software can unlock the bank
  assign wel_write      = reg_wr && (reg_addr == ADDR_WRITE_LATCH);
  assign wr_ok          = reg_wr && (write_enable_latch_q || wel_write);
  assign override_write = wr_ok && ((reg_addr == ADDR_LUT_ROW_OVR) || (reg_addr == ADDR_DAC_CODE_OVR));
  // No earlier result after reset, so the first one agrees with nothing
  assign upper_match    = first_seen_q && (adc_result[DATA_W-1 -: ROW_W] == last_upper_q);

  // Write acknowledge
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_ack_q  <= 1'b0;
      reg_nack_q <= 1'b0;
    end
    else
    begin
      reg_ack_q  <= wr_ok;
      reg_nack_q <= reg_wr && !wr_ok;
    end
  end

  // Write latch, volatile, cleared at power up
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      write_enable_latch_q <= 1'b0;
    else if (wel_write && reg_wdata == WEL_SET_CODE)
      write_enable_latch_q <= 1'b1;
    else if (wel_write && reg_wdata == WEL_CLEAR_CODE)
      write_enable_latch_q <= 1'b0;
  end

  // current_config; fixed bits are not stored, host keeps them as shown
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      current_sink_q               <= RST_DIRECTION;
      override_volatility_select_q <= RST_VOLATILITY;
      adc_filter_bypass_q          <= RST_BYPASS;
    end
    else if ((wr_ok && reg_addr == ADDR_CURRENT_CONFIG) || (nv_load && nv_load_addr == ADDR_CURRENT_CONFIG))
    begin
      current_sink_q               <= nv_load ? nv_load_data[CFG_DIRECTION_BIT] : reg_wdata[CFG_DIRECTION_BIT];
      override_volatility_select_q <= nv_load ? nv_load_data[CFG_VOLATILITY_BIT] : reg_wdata[CFG_VOLATILITY_BIT];
      adc_filter_bypass_q          <= nv_load ? nv_load_data[CFG_BYPASS_BIT] : reg_wdata[CFG_BYPASS_BIT];
    end
  end

  // Override registers, volatile copies
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lut_row_override_bits_q  <= RST_BYTE[ROW_W-1:0];
      dac_code_override_bits_q <= RST_BYTE;
    end
    else
    begin
      if (wr_ok && reg_addr == ADDR_LUT_ROW_OVR)
        lut_row_override_bits_q <= reg_wdata[ROW_W-1:0];
      else if (nv_load && nv_load_addr == ADDR_LUT_ROW_OVR)
        lut_row_override_bits_q <= nv_load_data[ROW_W-1:0];
      if (wr_ok && reg_addr == ADDR_DAC_CODE_OVR)
        dac_code_override_bits_q <= reg_wdata;
      else if (nv_load && nv_load_addr == ADDR_DAC_CODE_OVR)
        dac_code_override_bits_q <= nv_load_data;
    end
  end

  // source_and_range_select
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dac_direct_select_q <= RST_DAC_DIRECT;
      lut_direct_select_q <= RST_LUT_DIRECT;
      full_scale_range_q  <= RST_RANGE;
    end
    else if ((wr_ok && reg_addr == ADDR_SOURCE_RANGE) || (nv_load && nv_load_addr == ADDR_SOURCE_RANGE))
    begin
      dac_direct_select_q <= nv_load ? nv_load_data[SRC_DAC_DIRECT_BIT] : reg_wdata[SRC_DAC_DIRECT_BIT];
      lut_direct_select_q <= nv_load ? nv_load_data[SRC_LUT_DIRECT_BIT] : reg_wdata[SRC_LUT_DIRECT_BIT];
      full_scale_range_q  <= nv_load ? nv_load_data[SRC_RANGE_HI_BIT:SRC_RANGE_LO_BIT]
                                     : reg_wdata[SRC_RANGE_HI_BIT:SRC_RANGE_LO_BIT];
    end
  end

  // Nonvolatile write request; config registers always persist,
  // overrides only when volatility select is set
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      nv_wr_q   <= 1'b0;
      nv_addr_q <= RST_BYTE;
      nv_data_q <= RST_BYTE;
    end
    else
    begin
      nv_wr_q <= wr_ok && ((reg_addr == ADDR_CURRENT_CONFIG) || (reg_addr == ADDR_SOURCE_RANGE)
                 || (override_write && override_volatility_select_q));
      if (wr_ok)
      begin
        nv_addr_q <= reg_addr;
        nv_data_q <= reg_wdata;
      end
    end
  end

  // Conversion filter; a disagreeing result restarts the run
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_upper_q            <= RST_BYTE[ROW_W-1:0];
      agree_cnt_q             <= AGREE_ZERO;
      thermometer_code_bits_q <= RST_BYTE;
      status_valid_q          <= 1'b0;
      first_seen_q            <= 1'b0;
    end
    else if (adc_done)
    begin
      last_upper_q <= adc_result[DATA_W-1 -: ROW_W];
      first_seen_q <= 1'b1;
      if (!upper_match)
        agree_cnt_q <= AGREE_ZERO;
      else if (agree_cnt_q != AGREE_FULL)
        agree_cnt_q <= agree_cnt_q + 2'h1;
      if (adc_filter_bypass_q || (upper_match && agree_cnt_q == AGREE_FULL))
      begin
        thermometer_code_bits_q <= adc_result;
        status_valid_q          <= 1'b1;
      end
    end
  end

  // Row select and DAC source; DAC rests at zero until first valid result unless LUT or DAC direct select is set
  assign row_sel = lut_direct_select_q ? lut_row_override_bits_q
                                       : thermometer_code_bits_q[DATA_W-1 -: ROW_W];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lut_row_addr_q <= LUT_BASE_ADDR;
      dac_code_q     <= RST_BYTE;
    end
    else
    begin
      lut_row_addr_q <= LUT_BASE_ADDR + {2'h0, row_sel};
      if (dac_direct_select_q)
        dac_code_q <= dac_code_override_bits_q;
      else if (lut_direct_select_q || status_valid_q)
        dac_code_q <= lut_rdata;
      else
        dac_code_q <= RST_BYTE;
    end
  end

  // Read mux; reserved addresses and bits return zero
  always_comb
  begin
    rd_d = RST_BYTE;
    unique case (reg_addr)
      ADDR_CURRENT_CONFIG:
      begin
        rd_d[CFG_FIXED_ONE_BIT]  = 1'b1;
        rd_d[CFG_DIRECTION_BIT]  = current_sink_q;
        rd_d[CFG_VOLATILITY_BIT] = override_volatility_select_q;
        rd_d[CFG_BYPASS_BIT]     = adc_filter_bypass_q;
      end
      ADDR_LUT_ROW_OVR:  rd_d[ROW_W-1:0] = lut_row_override_bits_q;
      ADDR_DAC_CODE_OVR: rd_d = dac_code_override_bits_q;
      ADDR_SOURCE_RANGE:
      begin
        rd_d[SRC_DAC_DIRECT_BIT]                = dac_direct_select_q;
        rd_d[SRC_LUT_DIRECT_BIT]                = lut_direct_select_q;
        rd_d[SRC_RANGE_HI_BIT:SRC_RANGE_LO_BIT] = full_scale_range_q;
      end
      ADDR_WRITE_LATCH:  rd_d[WEL_BIT] = write_enable_latch_q;
      ADDR_TEMP_CODE:    rd_d = thermometer_code_bits_q;
      default:           rd_d = RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata_q <= RST_BYTE;
    else if (reg_rd)
      reg_rdata_q <= rd_d;
  end

  chk_bypass_update: assert property (@(posedge clk_sys) disable iff (!reset_n)
    adc_done && adc_filter_bypass_q |=> thermometer_code_bits_q == $past(adc_result))
    else $error("status missed an unfiltered conversion");

  chk_filter_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(thermometer_code_bits_q) && !$past(adc_filter_bypass_q)
    |-> $past(adc_done) && $past(agree_cnt_q) == AGREE_FULL && $past(upper_match))
    else $error("status changed without four agreeing conversions");

  chk_volatile_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
    override_write && !override_volatility_select_q |=> !nv_wr_q)
    else $error("volatile override write reached nonvolatile cells");

  chk_nv_mirror: assert property (@(posedge clk_sys) disable iff (!reset_n)
    override_write && override_volatility_select_q |=> nv_wr_q && nv_data_q == $past(reg_wdata))
    else $error("nonvolatile override write not issued");

  chk_direction_wr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_ok && reg_addr == ADDR_CURRENT_CONFIG && !nv_load |=> current_sink_q == $past(reg_wdata[CFG_DIRECTION_BIT]))
    else $error("direction bit not taken");

  chk_reserved_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd && (reg_addr == 8'h82 || reg_addr == 8'h84 || reg_addr[7:3] == 5'h11) |=> reg_rdata_q == RST_BYTE)
    else $error("reserved address read nonzero");

  chk_row_address: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> lut_row_addr_q == LUT_BASE_ADDR + {2'h0, $past(lut_direct_select_q) ? $past(lut_row_override_bits_q)
                               : $past(thermometer_code_bits_q[DATA_W-1 -: ROW_W])})
    else $error("LUT row address wrong");

  chk_dac_source: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> dac_code_q == ($past(dac_direct_select_q) ? $past(dac_code_override_bits_q)
             : ($past(lut_direct_select_q) || $past(status_valid_q)) ? $past(lut_rdata) : RST_BYTE))
    else $error("DAC source selection wrong");

  chk_latch_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_wr && !write_enable_latch_q && reg_addr != ADDR_WRITE_LATCH && !nv_load
    |=> reg_nack_q && !reg_ack_q && $stable(dac_code_override_bits_q) && $stable(current_sink_q))
    else $error("write taken while latch clear");
endmodule
